// file: rtl/drive_word_logic.sv
// Purpose: decode bus control word, assemble bus status word
// Assumes: drive core supplies its state flags on the same clock
// Notes:   control word latched whole when written with valid bit set
//
// How it works
// - bits 0..1 pick one of four presets
// - bit 2 low commands DC brake
// - bit 3 low coasts, output stage off
// - bit 4 low uses quick-stop ramp
// - bit 5 low freezes output frequency
// - frozen: only coast/brake stop accepted
// - bit 6 low ramps down to stop
// - trip reset only on rising bit 7
// - bit 8 selects jog speed
// - bit 9 selects second ramp pair
// - bit 10 low: word ignored
// - bits 11/12 drive relays if configured
// - bits 14:13 pick set-up if multi
// - bit 15 reverses if source permits
// - status 0..2: ready, drive ready, enable
// - status 3,4,6 faults; bit 5 zero
// - status 7 warning, 8 at reference
// - status 9 bus control possible
// - status 10 in limits, 11 running
// - status 12..15 temp, volt, torque, timer
// - link lost forces status to zero
// - 16384 equals 100 percent scaling
`timescale 1ns/1ns
`default_nettype none
module drive_word_logic (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // bus side words
  input  wire logic [15:0] control_command_word_i,
  input  wire logic        control_write_i,
  output logic      [15:0] status_report_word_o,
  input  wire logic [15:0] speed_ref_pct_i,
  output logic      [15:0] actual_frequency_value_o,
  // configuration
  input  wire logic        relay1_follows_bus_i,
  input  wire logic        relay2_follows_bus_i,
  input  wire logic        multi_setup_i,
  input  wire logic [1:0]  reverse_source_i,
  input  wire logic [1:0]  local_setup_i,
  input  wire logic [15:0] max_speed_i,
  // drive core state
  input  wire logic        tripped_i,
  input  wire logic        trip_locked_i,
  input  wire logic        error_no_trip_i,
  input  wire logic        warning_i,
  input  wire logic        power_ok_i,
  input  wire logic        din_coast_i,
  input  wire logic        din_stop_i,
  input  wire logic        local_mode_i,
  input  wire logic        at_reference_i,
  input  wire logic        in_speed_limit_i,
  input  wire logic        output_nonzero_i,
  input  wire logic        overtemp_i,
  input  wire logic        dc_voltage_bad_i,
  input  wire logic        current_limit_i,
  input  wire logic        thermal_timer_over_i,
  input  wire logic        link_ok_i,
  input  wire logic [15:0] actual_freq_pct_i,
  // drive commands
  output logic      [1:0]  preset_index_o,
  output logic             dc_brake_o,
  output logic             coast_o,
  output logic             quick_stop_o,
  output logic             hold_freq_o,
  output logic             ramp_stop_o,
  output logic             trip_reset_o,
  output logic             jog_o,
  output logic             ramp2_sel_o,
  output logic             relay1_o,
  output logic             relay2_o,
  output logic      [1:0]  setup_index_o,
  output logic             reverse_o,
  output logic      [15:0] speed_ref_o
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic        prev_reset;
    logic        reset_pulse;
    logic [15:0] status;
    logic [15:0] actual_frequency_value;
  } word_state_t;

  word_state_t st;
  word_state_t next_st;
  logic [15:0] stat_v;
  logic        frozen;
  logic        word_taken;

  function automatic logic cbit(input logic [15:0] w, input int pos);
    cbit = w[pos];
  endfunction : cbit

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (control_write_i &&
        cbit(control_command_word_i, drive_word_pkg::CB_VALID)) begin
      next_st.ctrl = control_command_word_i;
    end
    next_st.prev_reset  = cbit(st.ctrl, drive_word_pkg::CB_RESET);
    next_st.reset_pulse = cbit(st.ctrl, drive_word_pkg::CB_RESET) &&
                          !st.prev_reset;
    stat_v = drive_word_pkg::STAT_RESET;
    stat_v[drive_word_pkg::SB_CTRL_RDY] = !tripped_i;
    stat_v[drive_word_pkg::SB_DRV_RDY]  = !tripped_i && power_ok_i;
    stat_v[drive_word_pkg::SB_COAST_N]  = !coast_o;
    stat_v[drive_word_pkg::SB_TRIP]      = tripped_i;
    stat_v[drive_word_pkg::SB_ERROR]     = error_no_trip_i;
    stat_v[drive_word_pkg::SB_UNUSED]    = 1'b0;
    stat_v[drive_word_pkg::SB_TRIP_LOCK] = trip_locked_i;
    stat_v[drive_word_pkg::SB_WARNING] = warning_i;
    stat_v[drive_word_pkg::SB_AT_REF]  = at_reference_i;
    stat_v[drive_word_pkg::SB_BUS_CTRL] = !local_mode_i;
    stat_v[drive_word_pkg::SB_IN_LIMIT] = in_speed_limit_i;
    stat_v[drive_word_pkg::SB_RUNNING]  = output_nonzero_i ||
      cbit(st.ctrl, drive_word_pkg::CB_RUN);
    stat_v[drive_word_pkg::SB_OVERTEMP] = overtemp_i;
    stat_v[drive_word_pkg::SB_VOLTAGE]  = dc_voltage_bad_i;
    stat_v[drive_word_pkg::SB_TORQUE]   = current_limit_i;
    stat_v[drive_word_pkg::SB_TIMER]    = thermal_timer_over_i;
    next_st.status = link_ok_i ? stat_v : drive_word_pkg::STAT_RESET;
    next_st.actual_frequency_value = actual_freq_pct_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st.ctrl        <= drive_word_pkg::CTRL_RESET;
      st.prev_reset  <= 1'b0;
      st.reset_pulse <= 1'b0;
      st.status      <= drive_word_pkg::STAT_RESET;
      st.actual_frequency_value         <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoded commands from the one latched word, OR'd with din_coast_i/din_stop_i; set-up from local_setup_i unless multi
  // preset select
  assign preset_index_o = st.ctrl[drive_word_pkg::CB_REF_MSB:
                                  drive_word_pkg::CB_REF_LSB];
  assign frozen = !cbit(st.ctrl, drive_word_pkg::CB_HOLD_N);
  assign hold_freq_o = frozen;
  assign dc_brake_o = !cbit(st.ctrl, drive_word_pkg::CB_DC_BRAKE_N);
  assign coast_o = !cbit(st.ctrl, drive_word_pkg::CB_COAST_N) ||
                   din_coast_i;
  assign quick_stop_o = !frozen &&
                        !cbit(st.ctrl, drive_word_pkg::CB_QSTOP_N);
  assign ramp_stop_o = !frozen &&
                       (!cbit(st.ctrl, drive_word_pkg::CB_RUN) ||
                        din_stop_i);
  assign trip_reset_o = st.reset_pulse;
  assign jog_o = cbit(st.ctrl, drive_word_pkg::CB_JOG);
  assign ramp2_sel_o = cbit(st.ctrl, drive_word_pkg::CB_RAMP2);
  assign relay1_o = relay1_follows_bus_i &&
                    cbit(st.ctrl, drive_word_pkg::CB_RELAY1);
  assign relay2_o = relay2_follows_bus_i &&
                    cbit(st.ctrl, drive_word_pkg::CB_RELAY2);
  assign setup_index_o = multi_setup_i ?
    st.ctrl[drive_word_pkg::CB_SETUP_MSB:drive_word_pkg::CB_SETUP_LSB] :
    local_setup_i;
  assign reverse_o = cbit(st.ctrl, drive_word_pkg::CB_REVERSE) &&
                     (reverse_source_i != drive_word_pkg::REV_DIGITAL);
  assign status_report_word_o     = st.status;
  assign actual_frequency_value_o = st.actual_frequency_value;

  speed_scaler u_scaler (
    .mclk_i       (mclk_i),
    .reset_n_i    (reset_n_i),
    .pct_i        (speed_ref_pct_i),
    .full_scale_i (max_speed_i),
    .scaled_o     (speed_ref_o)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  // valid word offered on this edge, shared by the checks
  assign word_taken = control_write_i &&
                      cbit(control_command_word_i, drive_word_pkg::CB_VALID);
  AST_INVALID_IGNORED: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    control_write_i &&
    !cbit(control_command_word_i, drive_word_pkg::CB_VALID)
    |=> $stable(st.ctrl))
    else $error("invalid control word was taken");
  AST_ATOMIC_LOAD: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken
    |=> st.ctrl == $past(control_command_word_i))
    else $error("control word not loaded whole");
  AST_RESET_EDGE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    trip_reset_o |-> ##1 !trip_reset_o)
    else $error("trip reset longer than one cycle");
  AST_RESET_CAUSE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    trip_reset_o |-> $past(st.ctrl[drive_word_pkg::CB_RESET], 1) &&
                     !$past(st.ctrl[drive_word_pkg::CB_RESET], 2))
    else $error("trip reset without rising bit");
  AST_LINK_LOST: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    !link_ok_i |=> status_report_word_o == drive_word_pkg::STAT_RESET)
    else $error("status not cleared on link loss");
  AST_UNUSED_ZERO: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    status_report_word_o[drive_word_pkg::SB_UNUSED] == 1'b0)
    else $error("status bit five set");
  AST_TRIP_STATUS: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    link_ok_i && tripped_i |=>
      !status_report_word_o[drive_word_pkg::SB_CTRL_RDY] &&
      status_report_word_o[drive_word_pkg::SB_TRIP])
    else $error("trip not reported");
  AST_FROZEN_STOP: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    hold_freq_o |-> !ramp_stop_o && !quick_stop_o)
    else $error("ramp stop while frozen");
  AST_RELAY_GATE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    !relay1_follows_bus_i |-> !relay1_o)
    else $error("relay driven without config");
  AST_REVERSE_GATE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    reverse_source_i == drive_word_pkg::REV_DIGITAL |-> !reverse_o)
    else $error("reverse with digital source");
  AST_PRESET_INDEX: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken |=> preset_index_o == $past(control_command_word_i[
      drive_word_pkg::CB_REF_MSB:drive_word_pkg::CB_REF_LSB]))
    else $error("preset index not taken from word");
  AST_DC_BRAKE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken && !cbit(control_command_word_i, drive_word_pkg::CB_DC_BRAKE_N)
    |=> dc_brake_o)
    else $error("dc brake not commanded");
  AST_COAST: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken && !cbit(control_command_word_i, drive_word_pkg::CB_COAST_N)
    |=> coast_o)
    else $error("coast not commanded");
  AST_QUICK_STOP: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken && cbit(control_command_word_i, drive_word_pkg::CB_HOLD_N) &&
    !cbit(control_command_word_i, drive_word_pkg::CB_QSTOP_N)
    |=> quick_stop_o)
    else $error("quick stop not commanded");
  AST_HOLD_FREQ: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken |=> hold_freq_o ==
      !$past(control_command_word_i[drive_word_pkg::CB_HOLD_N]))
    else $error("hold output not following its bit");
  AST_FROZEN_COAST: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    hold_freq_o && din_coast_i |-> coast_o)
    else $error("coast refused while frozen");
  AST_RAMP_STOP: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken && cbit(control_command_word_i, drive_word_pkg::CB_HOLD_N) &&
    !cbit(control_command_word_i, drive_word_pkg::CB_RUN)
    |=> ramp_stop_o)
    else $error("ramp stop not commanded");
  AST_JOG: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken |=> jog_o ==
      $past(control_command_word_i[drive_word_pkg::CB_JOG]))
    else $error("jog not following its bit");
  AST_RAMP_PAIR: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken |=> ramp2_sel_o ==
      $past(control_command_word_i[drive_word_pkg::CB_RAMP2]))
    else $error("ramp pair not following its bit");
  AST_RELAY2_GATE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    !relay2_follows_bus_i |-> !relay2_o)
    else $error("relay two driven without config");
  AST_SETUP_LOCAL: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    !multi_setup_i |-> setup_index_o == local_setup_i)
    else $error("set-up taken from word outside multi mode");
  AST_REVERSE_BUS: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    word_taken && cbit(control_command_word_i, drive_word_pkg::CB_REVERSE) &&
    reverse_source_i != drive_word_pkg::REV_DIGITAL
    |=> reverse_o || reverse_source_i == drive_word_pkg::REV_DIGITAL)
    else $error("reverse not commanded");
  AST_DRIVE_READY: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    link_ok_i && !tripped_i && power_ok_i
    |=> status_report_word_o[drive_word_pkg::SB_DRV_RDY])
    else $error("drive ready not reported");
  AST_FAULT_BITS: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    link_ok_i |=> status_report_word_o[drive_word_pkg::SB_ERROR] ==
      $past(error_no_trip_i) &&
      status_report_word_o[drive_word_pkg::SB_TRIP_LOCK] ==
      $past(trip_locked_i))
    else $error("fault bits not reported");
  AST_WARNING: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    link_ok_i |=> status_report_word_o[drive_word_pkg::SB_WARNING] ==
      $past(warning_i))
    else $error("warning not reported");
  AST_LOCAL_MODE: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    local_mode_i |=> !status_report_word_o[drive_word_pkg::SB_BUS_CTRL])
    else $error("bus control shown in local mode");
  AST_RUNNING: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    link_ok_i && output_nonzero_i
    |=> status_report_word_o[drive_word_pkg::SB_RUNNING])
    else $error("running not reported");
  AST_PROTECT_BITS: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    link_ok_i |=> status_report_word_o[drive_word_pkg::SB_TIMER:
                                       drive_word_pkg::SB_OVERTEMP] ==
      $past({thermal_timer_over_i, current_limit_i, dc_voltage_bad_i,
             overtemp_i}))
    else $error("protection bits not reported");
  AST_FREQ_COPY: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    reset_n_i |=> actual_frequency_value_o == $past(actual_freq_pct_i))
    else $error("actual frequency word not passed on");
  COV_VALID_WORD: cover property (@(posedge mclk_i)
    word_taken);
  COV_TRIP_RESET: cover property (@(posedge mclk_i) trip_reset_o);
  COV_LINK_LOST: cover property (@(posedge mclk_i)
    link_ok_i ##1 !link_ok_i);
  COV_FROZEN_COAST: cover property (@(posedge mclk_i)
    hold_freq_o && coast_o);
  COV_REVERSE: cover property (@(posedge mclk_i) reverse_o);
endmodule : drive_word_logic
`default_nettype wire

// file: rtl/drive_word_pkg.sv
// Purpose: shared constants for the drive control/status word logic
// Assumes: 16-bit words from the fieldbus side, one clock domain
// Notes:   bit positions and scaling named once here
package drive_word_pkg;
  localparam int          WORD_W        = 16;
  // control word bit positions
  localparam int          CB_REF_LSB    = 0;
  localparam int          CB_REF_MSB    = 1;
  localparam int          CB_DC_BRAKE_N = 2;
  localparam int          CB_COAST_N    = 3;
  localparam int          CB_QSTOP_N    = 4;
  localparam int          CB_HOLD_N     = 5;
  localparam int          CB_RUN        = 6;
  localparam int          CB_RESET      = 7;
  localparam int          CB_JOG        = 8;
  localparam int          CB_RAMP2      = 9;
  localparam int          CB_VALID      = 10;
  localparam int          CB_RELAY1     = 11;
  localparam int          CB_RELAY2     = 12;
  localparam int          CB_SETUP_LSB  = 13;
  localparam int          CB_SETUP_MSB  = 14;
  localparam int          CB_REVERSE    = 15;
  // status word bit positions
  localparam int          SB_CTRL_RDY   = 0;
  localparam int          SB_DRV_RDY    = 1;
  localparam int          SB_COAST_N    = 2;
  localparam int          SB_TRIP       = 3;
  localparam int          SB_ERROR      = 4;
  localparam int          SB_UNUSED     = 5;
  localparam int          SB_TRIP_LOCK  = 6;
  localparam int          SB_WARNING    = 7;
  localparam int          SB_AT_REF     = 8;
  localparam int          SB_BUS_CTRL   = 9;
  localparam int          SB_IN_LIMIT   = 10;
  localparam int          SB_RUNNING    = 11;
  localparam int          SB_OVERTEMP   = 12;
  localparam int          SB_VOLTAGE    = 13;
  localparam int          SB_TORQUE     = 14;
  localparam int          SB_TIMER      = 15;
  // reset value of the control word: everything stopped, data invalid
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] STAT_RESET    = 16'h0000;
  // 16384 = 4000 hex stands for 100 percent
  localparam logic [15:0] SCALE_100PCT  = 16'h4000;
  localparam logic [1:0]  IDX_ZERO      = 2'h0;
  // reverse source selections; all but REV_DIGITAL let the bus reverse the motor
  localparam logic [1:0]  REV_DIGITAL   = 2'h0;
  localparam logic [1:0]  REV_BUS       = 2'h1;
  localparam logic [1:0]  REV_OR        = 2'h2;
  localparam logic [1:0]  REV_AND       = 2'h3;
endpackage : drive_word_pkg

// file: rtl/speed_scaler.sv
// Purpose: convert percent-scaled speed word to signed output reference
// Assumes: 16384 counts equal 100 percent, two's complement
// Notes:   product register breaks the multiply path
`timescale 1ns/1ns
`default_nettype none
module speed_scaler (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // percent word in, full scale in, scaled value out
  input  wire logic [15:0] pct_i,
  input  wire logic [15:0] full_scale_i,
  output logic      [15:0] scaled_o
);
  typedef struct packed {
    logic [15:0] scaled;
  } scale_state_t;

  scale_state_t st;
  scale_state_t next_st;
  logic signed [32:0] prod;

  ////////////////////////////////////////////////////////////////////
  // percent word scaling
  always_comb begin
    prod = $signed(pct_i) * $signed({1'b0, full_scale_i});
    next_st.scaled = prod[29:14];
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign scaled_o = st.scaled;
endmodule : speed_scaler
`default_nettype wire

// file: tb/bus_master_model.sv
// Purpose: fieldbus master model offering whole control words
// Assumes: the bench raises one request per cycle at most
// Notes:   an idle word bus shows the inverse of the last word
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
  // clock
  input  wire logic        mclk_i,
  // bench requests
  input  wire logic        req_i,
  input  wire logic [15:0] req_word_i,
  // bus side
  output logic      [15:0] word_o,
  output logic             write_o
);
  ////////////////////////////////////////////////////////////////////////
  // word offered whole
  // idle bus holds the inverse of the last word, so a stale word is
  // never mistaken for a fresh one
  always_ff @(posedge mclk_i) begin
    write_o <= req_i;
    word_o  <= req_i ? req_word_i : ~req_word_i;
  end
endmodule : bus_master_model
`default_nettype wire

// file: tb/drive_control_status_word_logic_tb.sv
// Purpose: self-checking bench for the control/status word logic
// Assumes: outputs settle within four cycles of a taken word
// Notes:   the whole status word is compared, ready bits included
`timescale 1ns/1ns
`default_nettype none
module drive_control_status_word_logic_tb;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        req = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic [15:0] word, stat, afv, spd, w, lat = 16'h0000;
  logic [15:0] pct = 16'h0000, mx = 16'h0000, afp = 16'h0000;
  logic        rf1 = 1'b0, rf2 = 1'b0, multi = 1'b0;
  logic        dcoast = 1'b0, dstop = 1'b0, wr, trst;
  logic [1:0]  rsrc = 2'h0, lset = 2'h0, pidx, sidx;
  logic [13:0] core = 14'h0000;
  logic        dcb, cst, qs, hld, rs, jog, r2, rl1, rl2, rev;
  logic [15:0] tbl [5] = '{16'h4000, 16'hC000, 16'h2000, 16'hE000, 16'h0000};
  logic signed [31:0] prod;
  int          err_total = 0, num_checks = 0, pulses = 0;

  always #10 mclk_i = ~mclk_i;
  always @(negedge mclk_i) if (trst === 1'b1) pulses++;

  bus_master_model i_master (.mclk_i(mclk_i), .req_i(req),
    .req_word_i(req_word), .word_o(word), .write_o(wr));

  drive_word_logic i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .control_command_word_i(word), .control_write_i(wr),
    .status_report_word_o(stat), .speed_ref_pct_i(pct),
    .actual_frequency_value_o(afv), .relay1_follows_bus_i(rf1),
    .relay2_follows_bus_i(rf2), .multi_setup_i(multi),
    .reverse_source_i(rsrc), .local_setup_i(lset), .max_speed_i(mx),
    .tripped_i(core[0]), .trip_locked_i(core[1]),
    .error_no_trip_i(core[2]), .warning_i(core[3]),
    .power_ok_i(core[4]), .din_coast_i(dcoast), .din_stop_i(dstop),
    .local_mode_i(core[5]), .at_reference_i(core[6]),
    .in_speed_limit_i(core[7]), .output_nonzero_i(core[8]),
    .overtemp_i(core[9]), .dc_voltage_bad_i(core[10]),
    .current_limit_i(core[11]), .thermal_timer_over_i(core[12]),
    .link_ok_i(core[13]), .actual_freq_pct_i(afp),
    .preset_index_o(pidx), .dc_brake_o(dcb), .coast_o(cst),
    .quick_stop_o(qs), .hold_freq_o(hld), .ramp_stop_o(rs),
    .trip_reset_o(trst), .jog_o(jog), .ramp2_sel_o(r2), .relay1_o(rl1),
    .relay2_o(rl2), .setup_index_o(sidx), .reverse_o(rev),
    .speed_ref_o(spd));

  ////////////////////////////////////////////////////////////////////////
  // frozen output masks ramp and quick stop, not coast or brake
  function automatic logic [15:0] exp_cmd(input logic [15:0] c);
    return {2'h0, c[1:0], ~c[2], ~c[3] | dcoast, ~c[4] & c[5], ~c[5],
            (~c[6] | dstop) & c[5], c[8], c[9], c[11] & rf1, c[12] & rf2,
            multi ? c[14:13] : lset, c[15] & (rsrc != 2'h0)};
  endfunction : exp_cmd

  // bit 1 needs power and no trip, bit 2 drops while coasting
  function automatic logic [15:0] exp_stat();
    return core[13] ? {core[12:9], core[8] | lat[6], core[7], ~core[5],
                       core[6], core[3], core[1], 1'b0, core[2], core[0],
                       lat[3] & ~dcoast, core[4] & ~core[0],
                       ~core[0]} : 16'h0000;
  endfunction : exp_stat

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle();
    repeat (4) @(posedge mclk_i);
    #1;
  endtask : settle

  task automatic send(input logic [15:0] c);
    @(posedge mclk_i);
    req <= 1'b1;
    req_word <= c;
    if (c[10]) lat = c;
    @(posedge mclk_i);
    req <= 1'b0;
    settle();
  endtask : send

  task automatic cmp_cmd();
    check({2'h0, pidx, dcb, cst, qs, hld, rs, jog, r2, rl1, rl2, sidx, rev},
          exp_cmd(lat));
  endtask : cmp_cmd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk_i);
    err_total++;
    complete_run();
  end

  initial begin
    void'($urandom(21));
    repeat (15) @(posedge mclk_i);
    #1;
    check(stat, 16'h0000);
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    settle();
    cmp_cmd();
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      @(posedge mclk_i);
      {rf1, rf2, dcoast, dstop, lset} <= 6'($urandom);
      multi <= i[2];
      rsrc <= 2'(i);
      send(16'($urandom) | (i[3] ? 16'h0000 : 16'h0400));
      cmp_cmd();
    end
    $display("test command decode done");
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom) | 16'h0400;
      req <= 1'b1;
      req_word <= w;
      lat = w;
      @(posedge mclk_i);
    end
    req <= 1'b0;
    settle();
    cmp_cmd();
    $display("test burst done");
    send(16'h0420);
    pulses = 0;
    send(16'h04A0);
    check(16'(pulses), 16'h0001);
    pulses = 0;
    send(16'h04A0);
    send(16'h0020);
    check(16'(pulses), 16'h0000);
    $display("test trip reset done");
    for (int i = 0; i < 24; i++) begin
      @(posedge mclk_i);
      core <= 14'($urandom) | (i < 20 ? 14'h2000 : 14'h0000);
      afp <= 16'($urandom);
      settle();
      check(stat, exp_stat());
      check(afv, afp);
    end
    $display("test status done");
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk_i);
      pct <= tbl[k];
      mx <= 16'($urandom) & 16'h7FFE;
      settle();
      prod = $signed(pct) * $signed({16'h0000, mx});
      check(spd, 16'(prod >>> 14));
    end
    $display("test scaling done");
    complete_run();
  end
endmodule : drive_control_status_word_logic_tb
`default_nettype wire
